//--- ledi2c_pkg.sv
package ledi2c_pkg;
  // ----------------------------------------
  // bus timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int NOISE_MAX_NS = 100;
  localparam int NOISE_CYC = (NOISE_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] ADDR_FIXED = 4'hC;
  // ----------------------------------------
  // ahb register map
  // ----------------------------------------
  localparam logic [7:0] OFS_INPUT0 = 8'h00;
  localparam logic [7:0] OFS_INPUT1 = 8'h04;
  localparam logic [7:0] OFS_PSC0 = 8'h08;
  localparam logic [7:0] OFS_PWM0 = 8'h0C;
  localparam logic [7:0] OFS_PSC1 = 8'h10;
  localparam logic [7:0] OFS_PWM1 = 8'h14;
  localparam logic [7:0] OFS_LS0 = 8'h18;
  localparam logic [7:0] OFS_LS1 = 8'h1C;
  localparam logic [7:0] OFS_LS2 = 8'h20;
  localparam logic [7:0] OFS_LS3 = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_GPIO = 8'h2C;
  localparam int NUM_REGS = 10;
  localparam logic [3:0] LAST_REG = 4'h9;
  localparam logic [7:0] RST_PSC = 8'hFF;
  localparam logic [7:0] RST_PWM = 8'h80;
  localparam logic [7:0] RST_LS = 8'h55;
  localparam logic [1:0] LS_ON = 2'h0;
  localparam logic [1:0] LS_OFF = 2'h1;
  localparam logic [1:0] LS_RATE0 = 2'h2;
  localparam logic [1:0] LS_RATE1 = 2'h3;
  typedef enum logic [2:0] {LI_IDLE, LI_ADDR, LI_ACK, LI_RX, LI_TX, LI_MACK, LI_WAIT} ledi_st_t;
endpackage

//--- ledi_glitch.sv
`timescale 1ns/1ps
`default_nettype none
module ledi_glitch
  import ledi2c_pkg::*;
#(
  parameter int FILT = NOISE_CYC
) (
  input wire logic mclk,  // clock
  input wire logic reset, // async reset
  input wire logic pin,   // raw pin
  output logic clean      // filtered level
);
  if (FILT < 1 || FILT > 255) begin : g_bad_filt
    $error("bad FILT");
  end
  logic s1_ff, s2_ff, clean_ff, nxt_clean;
  logic [7:0] cnt_ff, nxt_cnt;
  // ----------------------------------------
  // sync then hold-off filter
  // ----------------------------------------
  always_comb begin
    nxt_clean = clean_ff;
    nxt_cnt = 8'h00;
    if (s2_ff != clean_ff) begin
      nxt_cnt = cnt_ff + 8'h01;
      if (cnt_ff >= 8'(FILT)) begin
        nxt_clean = s2_ff;
        nxt_cnt = 8'h00;
      end
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      clean_ff <= 1'b1;
      cnt_ff <= 8'h00;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      clean_ff <= nxt_clean;
      cnt_ff <= nxt_cnt;
    end
  end
  assign clean = clean_ff;
endmodule // ledi_glitch
`default_nettype wire

//--- ledi_top.sv
`timescale 1ns/1ps
`default_nettype none
module ledi_top
  import ledi2c_pkg::*;
(
  input wire logic mclk,              // 200 MHz clock
  input wire logic reset,             // async reset, high
  input wire logic reset_pin_n,       // device reset pin, low
  input wire logic scl_in,            // serial clock pin
  input wire logic sda_in,            // serial data pin level
  output logic sda_out,               // always 0
  output logic sda_oe,                // high pulls sda low
  input wire logic addr_select_bit0,  // address strap 0
  input wire logic addr_select_bit1,  // address strap 1
  input wire logic addr_select_bit2,  // address strap 2
  input wire logic [15:0] ind_in,     // indicator pin levels
  output logic [15:0] indicator_outputs_oe, // high pulls pin low
  input wire logic first_flash_rate,  // blink source 0 level
  input wire logic second_flash_rate, // blink source 1 level
  input wire logic [31:0] haddr,      // ahb address
  input wire logic [1:0] htrans,      // ahb transfer type
  input wire logic hwrite,            // ahb write
  input wire logic [2:0] hsize,       // ahb size
  input wire logic [31:0] hwdata,     // ahb write data
  input wire logic hsel,              // ahb select
  input wire logic hready,            // ahb ready in
  output logic [31:0] hrdata,         // ahb read data
  output logic hreadyout,             // ahb ready out
  output logic hresp                  // ahb response
);
  logic scl_f, sda_f, scl_d_ff, sda_d_ff;
  logic rp1_ff, rp2_ff, a1_ff, a2_ff, b1_ff, b2_ff;
  logic [15:0] in1_ff, in2_ff;
  logic [2:0] sel1_ff, sel_ff;
  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] nxt_regs [NUM_REGS];
  ledi_st_t st_ff, nxt_st;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] ptr_ff, nxt_ptr;
  logic ptr_vld_ff, nxt_ptr_vld, rd_ff, nxt_rd, oe_ff, nxt_oe;
  logic hw_ff, nxt_hw;
  logic [7:0] ha_ff, nxt_ha;
  logic [31:0] hrd_ff, nxt_hrd;
  logic start, stop, scl_rise, scl_fall, soft_rst;
  logic [7:0] rd_byte;
  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  // noise filter, two-flop sync inside
  ledi_glitch #(.FILT(NOISE_CYC)) u_fscl (.mclk(mclk), .reset(reset), .pin(scl_in), .clean(scl_f));
  ledi_glitch #(.FILT(NOISE_CYC)) u_fsda (.mclk(mclk), .reset(reset), .pin(sda_in), .clean(sda_f));
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {scl_d_ff, sda_d_ff} <= 2'h3;
      {rp1_ff, rp2_ff} <= 2'h0;
      {a1_ff, a2_ff, b1_ff, b2_ff} <= 4'h0;
      {in1_ff, in2_ff} <= 32'h0000_0000;
      {sel1_ff, sel_ff} <= 6'h00;
    end else begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
      rp1_ff <= reset_pin_n;
      rp2_ff <= rp1_ff;
      a1_ff <= first_flash_rate;
      a2_ff <= a1_ff;
      b1_ff <= second_flash_rate;
      b2_ff <= b1_ff;
      in1_ff <= ind_in;
      in2_ff <= in1_ff;
      // straps are pins too, so they get the same two-flop sync
      sel1_ff <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
      sel_ff <= sel1_ff;
    end
  end
  assign soft_rst = ~rp2_ff;
  assign start = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
  assign stop = scl_f & scl_d_ff & ~sda_d_ff & sda_f;
  assign scl_rise = scl_f & ~scl_d_ff;
  assign scl_fall = ~scl_f & scl_d_ff;
  // register 0/1 show live pin levels
  always_comb begin
    rd_byte = 8'h00;
    case (ptr_ff[3:0])
      4'h0: rd_byte = in2_ff[7:0];
      4'h1: rd_byte = in2_ff[15:8];
      default: if (ptr_ff[3:0] <= LAST_REG) rd_byte = regs_ff[ptr_ff[3:0]];
    endcase
  end
  // ----------------------------------------
  // serial state machine
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_ptr_vld = ptr_vld_ff;
    nxt_rd = rd_ff;
    nxt_oe = oe_ff;
    for (int i = 0; i < NUM_REGS; i++) nxt_regs[i] = regs_ff[i];
    if (hw_ff && ha_ff >= OFS_PSC0 && ha_ff <= OFS_LS3 && ha_ff[1:0] == 2'h0) nxt_regs[ha_ff[5:2]] = hwdata[7:0];
    if (start) begin
      nxt_st = LI_ADDR;
      nxt_bit = 4'h0;
      nxt_oe = 1'b0;
      nxt_ptr_vld = 1'b0;
    end else if (stop) begin
      nxt_st = LI_IDLE;
      nxt_oe = 1'b0;
    end else begin
      case (st_ff)
        LI_IDLE: nxt_oe = 1'b0;
        LI_ADDR, LI_RX: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_f};
            nxt_bit = bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'h8) begin
            if (st_ff == LI_ADDR) begin
              if (sh_ff[7:4] == ADDR_FIXED && sh_ff[3:1] == sel_ff) begin
                nxt_rd = sh_ff[0];
                nxt_oe = 1'b1;
                nxt_st = LI_ACK;
              end else begin
                nxt_st = LI_WAIT;
              end
            end else begin
              if (!ptr_vld_ff) begin
                nxt_ptr = sh_ff;
                nxt_ptr_vld = 1'b1;
              end else begin
                if (ptr_ff[3:0] >= 4'h2 && ptr_ff[3:0] <= LAST_REG) nxt_regs[ptr_ff[3:0]] = sh_ff;
                if (ptr_ff[4])
                  nxt_ptr[3:0] = (ptr_ff[3:0] >= LAST_REG) ? 4'h0 : ptr_ff[3:0] + 4'h1;
              end
              nxt_oe = 1'b1;
              nxt_st = LI_ACK;
            end
          end
        end
        LI_ACK: if (scl_fall) begin
          nxt_bit = 4'h0;
          if (rd_ff) begin
            nxt_sh = rd_byte;
            nxt_oe = ~rd_byte[7];
            nxt_st = LI_TX;
          end else begin
            nxt_oe = 1'b0;
            nxt_st = LI_RX;
          end
        end
        LI_TX: begin
          if (scl_rise) nxt_bit = bit_ff + 4'h1;
          if (scl_fall) begin
            nxt_sh = {sh_ff[6:0], 1'b1};
            if (bit_ff == 4'h8) begin
              nxt_oe = 1'b0;
              nxt_st = LI_MACK;
              if (ptr_ff[4]) nxt_ptr[3:0] = (ptr_ff[3:0] >= LAST_REG) ? 4'h0 : ptr_ff[3:0] + 4'h1;
            end else begin
              nxt_oe = ~sh_ff[6];
            end
          end
        end
        LI_MACK: if (scl_rise) begin
          nxt_bit = 4'h0;
          nxt_st = sda_f ? LI_WAIT : LI_ACK;
          nxt_rd = 1'b1;
        end
        LI_WAIT: nxt_oe = 1'b0;
        default: nxt_st = LI_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= LI_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      ptr_vld_ff <= 1'b0;
      rd_ff <= 1'b0;
      oe_ff <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= 8'h00;
      regs_ff[2] <= RST_PSC;
      regs_ff[3] <= RST_PWM;
      regs_ff[4] <= RST_PSC;
      regs_ff[5] <= RST_PWM;
      for (int i = 6; i < NUM_REGS; i++) regs_ff[i] <= RST_LS;
    end else if (soft_rst) begin
      st_ff <= LI_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      ptr_vld_ff <= 1'b0;
      rd_ff <= 1'b0;
      oe_ff <= 1'b0;
      regs_ff[2] <= RST_PSC;
      regs_ff[3] <= RST_PWM;
      regs_ff[4] <= RST_PSC;
      regs_ff[5] <= RST_PWM;
      for (int i = 6; i < NUM_REGS; i++) regs_ff[i] <= RST_LS;
    end else begin
      st_ff <= nxt_st;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      ptr_vld_ff <= nxt_ptr_vld;
      rd_ff <= nxt_rd;
      oe_ff <= nxt_oe;
      for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= nxt_regs[i];
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;
  // ----------------------------------------
  // indicator outputs
  // ----------------------------------------
  // per-pin selector
  genvar g;
  for (g = 0; g < 16; g++) begin : g_ind
    logic [1:0] mode;
    assign mode = regs_ff[6 + g / 4][(g % 4) * 2 +: 2];
    assign indicator_outputs_oe[g] = (mode == LS_ON) | ((mode == LS_RATE0) & a2_ff) | ((mode == LS_RATE1) & b2_ff);
  end
  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  always_comb begin
    nxt_hw = 1'b0;
    nxt_ha = ha_ff;
    nxt_hrd = hrd_ff;
    if (hsel && hready && htrans[1]) begin
      nxt_hw = hwrite & ~soft_rst;
      nxt_ha = haddr[7:0];
      nxt_hrd = 32'h0000_0000;
      case (haddr[7:0])
        OFS_INPUT0: nxt_hrd = {24'h000000, in2_ff[7:0]};
        OFS_INPUT1: nxt_hrd = {24'h000000, in2_ff[15:8]};
        OFS_STATUS: nxt_hrd = {20'h00000, ptr_ff, 1'b0, 3'(st_ff)};
        OFS_GPIO: nxt_hrd = {16'h0000, indicator_outputs_oe};
        default: if (haddr[7:0] <= OFS_LS3 && haddr[1:0] == 2'h0) nxt_hrd = {24'h000000, regs_ff[haddr[5:2]]};
      endcase
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hw_ff <= 1'b0;
      ha_ff <= 8'h00;
      hrd_ff <= 32'h0000_0000;
    end else begin
      hw_ff <= nxt_hw;
      ha_ff <= nxt_ha;
      hrd_ff <= nxt_hrd;
    end
  end
  assign hrdata = hrd_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_addr_done;
    st_ff == LI_ADDR && bit_ff == 4'h8 && scl_fall && !start && !stop && !soft_rst;
  endsequence
  property p_start_go;
    @(posedge mclk) disable iff (reset) start && !soft_rst |=> st_ff == LI_ADDR && bit_ff == 4'h0;
  endproperty
  a_start_go: assert property (p_start_go) else $error("start not taken");
  property p_stop_idle;
    @(posedge mclk) disable iff (reset) stop && !start && !soft_rst |=> st_ff == LI_IDLE && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");
  property p_match_ack;
    @(posedge mclk) disable iff (reset)
      s_addr_done ##0 (sh_ff[7:4] == ADDR_FIXED && sh_ff[3:1] == sel_ff) |=> sda_oe && st_ff == LI_ACK;
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("no ack on match");
  property p_nomatch;
    @(posedge mclk) disable iff (reset)
      s_addr_done ##0 !(sh_ff[7:4] == ADDR_FIXED && sh_ff[3:1] == sel_ff) |=> !sda_oe && st_ff == LI_WAIT;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("acked foreign address");
  property p_dir;
    @(posedge mclk) disable iff (reset)
      s_addr_done ##0 (sh_ff[7:4] == ADDR_FIXED && sh_ff[3:1] == sel_ff) |=> rd_ff == $past(sh_ff[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_rst_hold;
    @(posedge mclk) disable iff (reset) soft_rst |=> st_ff == LI_IDLE && !sda_oe && regs_ff[6] == RST_LS;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not held");
  property p_wait_quiet;
    @(posedge mclk) disable iff (reset) st_ff == LI_WAIT |-> !sda_oe;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("sda driven while waiting");
  property p_on_low;
    @(posedge mclk) disable iff (reset) regs_ff[6][1:0] == LS_ON |-> indicator_outputs_oe[0];
  endproperty
  a_on_low: assert property (p_on_low) else $error("on pin not pulled");
endmodule // ledi_top
`default_nettype wire

//--- ledi_mst_model.sv
`timescale 1ns/1ps
`default_nettype none
module ledi_mst_model #(
  parameter int Q = 160
) (
  output logic scl_low, // high pulls scl down
  output logic sda_low, // high pulls sda down
  input wire logic scl,  // wired scl level
  input wire logic sda   // wired sda level
);
  // ----------------------------------------
  // idle: both lines released to pull-up
  // ----------------------------------------
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b1;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b0;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask
  // sda moves only while scl low
  task automatic clk_bit(input logic b, output logic s);
    sda_low = !b;
    #Q;
    scl_low = 1'b0;
    #(Q/2);
    s = sda;
    #(Q/2);
    scl_low = 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(!mack, s);
  endtask
  // short scl pulse while scl low, must be filtered out
  task automatic glitch();
    #Q;
    scl_low = 1'b0;
    #50;
    scl_low = 1'b1;
    #Q;
  endtask
endmodule // ledi_mst_model
`default_nettype wire

//--- ledi_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ledi_top_bench
  import ledi2c_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, reset_pin_n = 1'b1;
  logic first_flash_rate = 1'b0, second_flash_rate = 1'b0;
  logic [15:0] ind_in = 16'h3CA5;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, hsel = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, sda_out, sda_oe, scl_low, sda_low;
  wire logic [15:0] ind_oe;
  wire logic scl = !scl_low;
  wire logic sda = !(sda_low || (sda_oe && !sda_out));
  int fail_count = 0, n_checks = 0;
  logic ack;
  logic [7:0] rb;
  logic [31:0] rd;
  always #2.5 mclk = !mclk;
  // blink sources stepped on clock edges like the ahb and reset inputs
  always begin
    repeat (226) @(posedge mclk);
    first_flash_rate <= !first_flash_rate;
  end
  always begin
    repeat (346) @(posedge mclk);
    second_flash_rate <= !second_flash_rate;
  end
  ledi_top dut_u (.mclk(mclk), .reset(reset), .reset_pin_n(reset_pin_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(1'b1), .addr_select_bit1(1'b0),
    .addr_select_bit2(1'b1), .ind_in(ind_in), .indicator_outputs_oe(ind_oe),
    .first_flash_rate(first_flash_rate), .second_flash_rate(second_flash_rate), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  ledi_mst_model mst_u (.scl_low(scl_low), .sda_low(sda_low), .scl(scl), .sda(sda));
  // ----------------------------------------
  // ahb-lite master tasks
  // ----------------------------------------
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, {24'h0, a}, 32'h0, rd);
    chk(what, exp, rd);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    tally_and_finish();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    logic [7:0] ofs [8] = '{OFS_PSC0, OFS_PWM0, OFS_PSC1, OFS_PWM1, OFS_LS0, OFS_LS1, OFS_LS2, OFS_LS3};
    logic [7:0] dft [8] = '{RST_PSC, RST_PWM, RST_PSC, RST_PWM, RST_LS, RST_LS, RST_LS, RST_LS};
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdchk("default", ofs[i], {24'h0, dft[i]});
    end
    rdchk("unmapped", 8'h40, 32'h0);
    rdchk("input1", OFS_INPUT1, {24'h0, ind_in[15:8]});
    rdchk("gpio", OFS_GPIO, 32'h0);
    rdchk("status", OFS_STATUS, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    // pointer to LS0 with auto-advance, three data bytes
    mst_u.start();
    mst_u.wbyte(8'hCA, ack);
    chk("addr ack", 1, ack);
    mst_u.wbyte(8'h16, ack);
    chk("ptr ack", 1, ack);
    mst_u.wbyte(8'h00, ack);
    chk("data ack", 1, ack);
    mst_u.wbyte(8'hAA, ack);
    chk("data ack", 1, ack);
    mst_u.wbyte(8'hFF, ack);
    chk("data ack", 1, ack);
    mst_u.stop();
    rdchk("ls0", OFS_LS0, 32'h0);
    rdchk("ls1", OFS_LS1, 32'hAA);
    rdchk("ls2", OFS_LS2, 32'hFF);
    chk("led on", 32'hF, {28'h0, ind_oe[3:0]});
    chk("led off", 32'h0, {28'h0, ind_oe[15:12]});
    // blinking pins follow their source once it has settled
    @(first_flash_rate);
    repeat (4) @(posedge mclk);
    chk("blink0", {31'h0, first_flash_rate}, {31'h0, ind_oe[4]});
    @(second_flash_rate);
    repeat (4) @(posedge mclk);
    chk("blink1", {31'h0, second_flash_rate}, {31'h0, ind_oe[8]});
    // strap mismatch, then fixed nibble mismatch
    mst_u.start();
    mst_u.wbyte(8'hC8, ack);
    chk("strap nack", 0, ack);
    mst_u.wbyte(8'h00, ack);
    chk("released", 0, ack);
    mst_u.stop();
    mst_u.start();
    mst_u.wbyte(8'h8A, ack);
    chk("fixed nack", 0, ack);
    mst_u.stop();
    // read LS3 then wrap to INPUT0, master nacks the last
    mst_u.start();
    mst_u.wbyte(8'hCA, ack);
    mst_u.wbyte(8'h19, ack);
    chk("ptr ack", 1, ack);
    mst_u.stop();
    mst_u.start();
    mst_u.wbyte(8'hCB, ack);
    chk("read ack", 1, ack);
    mst_u.rbyte(1'b1, rb);
    chk("rd ls3", {24'h0, RST_LS}, {24'h0, rb});
    mst_u.rbyte(1'b0, rb);
    chk("rd wrap", 32'hA5, {24'h0, rb});
    mst_u.stop();
    // short scl pulse inside a frame must not count as a bit
    mst_u.start();
    mst_u.glitch();
    mst_u.wbyte(8'hCA, ack);
    chk("glitch ignored", 1, ack);
    mst_u.stop();
    // device reset pin restores and holds defaults
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk("pin reset", OFS_LS0, {24'h0, RST_LS});
    ahb(1'b1, {24'h0, OFS_LS0}, 32'h0, rd);
    rdchk("held", OFS_LS0, {24'h0, RST_LS});
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge mclk);
    tally_and_finish();
  end
endmodule // ledi_top_bench
`default_nettype wire
